// *** src/eprom_eeprom_program_control.sv ***
/*
 Program and erase control for program memory and byte-erasable data memory,
 with APB register access. Assumes the memory arrays, charge pump and mode
 logic sit outside and follow the strobes and latched values given here.
*/
`timescale 1ns/1ps
`default_nettype none
module eprom_eeprom_program_control
   import nvm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic special_mode,
   input wire logic data_memory_map_enable,
   input wire logic vdd_unsafe,
   input wire logic [15:0] mem_addr,
   input wire logic mem_write,
   input wire logic [7:0] mem_wdata,
   input wire logic pm_write,
   output logic pm_read_enable,
   output logic pm_user_array_enable,
   output logic [11:0] pm_decode_addr,
   output logic pm_addr_bit5_ignore,
   output logic [15:0] pm_latch_addr,
   output logic [7:0] pm_latch_data,
   output logic pm_voltage_on,
   output logic dm_read_select,
   output logic [9:0] dm_latch_offset,
   output logic [7:0] dm_latch_data,
   output logic dm_erase_mode,
   output erase_scope_type dm_erase_scope,
   output logic dm_op_refused,
   output logic dm_voltage_on
);
   // Control state
   logic multi_byte_program_enable;
   logic prog_memory_latch_control;
   logic extra_column_select;
   logic extra_row_select;
   logic prog_memory_voltage_enable;
   logic byte_sel;
   logic row_sel;
   logic erase_sel;
   logic data_memory_latch_control;
   logic data_memory_program_command;
   logic low_voltage_inhibit_flag;
   logic [7:0] block_protect;
   logic [3:0] data_memory_page;
   logic map_locked;
   logic protect_cleared;
   logic [6:0] reset_cycles;
   logic armed;

   // Bus decode
   logic setup_phase;
   logic write_access;
   logic [7:0] wd;
   logic hit_pm;
   logic hit_dm;
   logic hit_bp;
   logic hit_map;
   logic mapped;
   logic [7:0] pm_read_val;
   logic [7:0] dm_read_val;
   logic [7:0] read_val;

   // Data-memory capture and protection
   logic low_voltage_protect_enable;
   logic bulk_erase_protect;
   logic [4:0] protect_blocks;
   logic low_voltage_inhibit_flag_active;
   logic dm_capture;
   logic protected_hit;
   logic any_protect;
   logic next_refused;
   erase_scope_type scope_now;
   logic [9:0] next_offset;
   logic window_open;
   logic [7:0] next_block_protect;
   logic next_dm_voltage;

   dm_target_if tgt();

   dm_target_decode u_decode (
      .t(tgt.decoder)
   );

   // APB strobes, zero-wait answer
   assign setup_phase = psel && !penable;
   assign write_access = psel && penable && pwrite;
   assign wd = pwdata[7:0];
   assign hit_pm = (paddr == OFS_PM_CTRL);
   assign hit_dm = (paddr == OFS_DM_CTRL);
   assign hit_bp = (paddr == OFS_BLOCK_PROTECT);
   assign hit_map = (paddr == OFS_DM_MAP);
   assign mapped = hit_pm || hit_dm || hit_bp || hit_map;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Read views with mode-gated and unimplemented bits
   assign pm_read_val = {multi_byte_program_enable && special_mode, 1'b0,
      prog_memory_latch_control, extra_column_select && special_mode,
      extra_row_select && special_mode, 2'h0, prog_memory_voltage_enable};
   assign dm_read_val = {2'h0, low_voltage_inhibit_flag_active, byte_sel, row_sel, erase_sel,
      data_memory_latch_control, data_memory_program_command};
   assign read_val = hit_pm ? pm_read_val :
      hit_dm ? dm_read_val :
      hit_bp ? block_protect :
      hit_map ? {data_memory_page, 4'h0} : 8'h00;

   // Read data taken in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata <= {24'h00_0000, read_val};
      end
   end

   // Program-memory control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         multi_byte_program_enable <= PM_CTRL_RESET[PM_MBE];
         prog_memory_latch_control <= PM_CTRL_RESET[PM_PROG_MEMORY_LATCH_CONTROL];
         extra_column_select <= PM_CTRL_RESET[PM_EXTRA_COLUMN_SELECT];
         extra_row_select <= PM_CTRL_RESET[PM_EXTRA_ROW_SELECT];
         prog_memory_voltage_enable <= PM_CTRL_RESET[PM_PROG_MEMORY_VOLTAGE_ENABLE];
      end else if (write_access && hit_pm) begin
         if (special_mode) begin
            multi_byte_program_enable <= wd[PM_MBE];
            extra_column_select <= wd[PM_EXTRA_COLUMN_SELECT];
            extra_row_select <= wd[PM_EXTRA_ROW_SELECT];
         end
         if (!prog_memory_voltage_enable) begin
            prog_memory_latch_control <= wd[PM_PROG_MEMORY_LATCH_CONTROL];
         end
         if (prog_memory_latch_control) begin
            prog_memory_voltage_enable <= wd[PM_PROG_MEMORY_VOLTAGE_ENABLE];
         end
      end
   end

   // Program-memory address path
   assign pm_read_enable = !prog_memory_latch_control;
   assign pm_user_array_enable = !(extra_column_select || extra_row_select);
   assign pm_decode_addr = extra_column_select ? {mem_addr[11:5], 5'h00} :
      extra_row_select ? {6'h00, mem_addr[5:0]} : mem_addr[11:0];
   assign pm_addr_bit5_ignore = multi_byte_program_enable;
   assign pm_voltage_on = prog_memory_voltage_enable;

   // Capture of the program-memory target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_latch_addr <= 16'h0000;
         pm_latch_data <= 8'h00;
      end else if (pm_write && prog_memory_latch_control) begin
         pm_latch_addr <= mem_addr;
         pm_latch_data <= mem_wdata;
      end
   end

   // Data-memory control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_sel <= DM_CTRL_RESET[DM_BYTE];
         row_sel <= DM_CTRL_RESET[DM_ROW];
         erase_sel <= DM_CTRL_RESET[DM_ERASE];
         data_memory_latch_control <= DM_CTRL_RESET[DM_DATA_MEMORY_LATCH_CONTROL];
         data_memory_program_command <= DM_CTRL_RESET[DM_DATA_MEMORY_PROGRAM_COMMAND];
      end else if (write_access && hit_dm) begin
         byte_sel <= wd[DM_BYTE];
         row_sel <= wd[DM_ROW];
         erase_sel <= wd[DM_ERASE];
         data_memory_latch_control <= wd[DM_DATA_MEMORY_LATCH_CONTROL];
         data_memory_program_command <= wd[DM_DATA_MEMORY_PROGRAM_COMMAND];
      end
   end

   // Low-voltage inhibit follows supply while protection is enabled
   assign low_voltage_protect_enable = block_protect[BP_LOW_VOLTAGE_PROTECT_ENABLE];
   assign low_voltage_inhibit_flag_active = low_voltage_inhibit_flag && low_voltage_protect_enable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_voltage_inhibit_flag <= 1'b0;
      end else begin
         low_voltage_inhibit_flag <= low_voltage_protect_enable && vdd_unsafe;
      end
   end

   // Cycle count for the protect-clear window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_cycles <= 7'h00;
      end else if (reset_cycles < BLOCK_PROTECT_WINDOW) begin
         reset_cycles <= reset_cycles + 7'h01;
      end
   end

   // Protect bits clear once early in normal modes; set freely
   assign window_open = (reset_cycles < BLOCK_PROTECT_WINDOW) && !protect_cleared;
   assign next_block_protect = (special_mode || window_open) ? wd : (block_protect | wd);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_protect <= BLOCK_PROTECT_RESET;
         protect_cleared <= 1'b0;
      end else if (write_access && hit_bp) begin
         block_protect <= next_block_protect;
         if (!special_mode && window_open) begin
            protect_cleared <= 1'b1;
         end
      end
   end

   // Data-memory page register, written once in normal modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_memory_page <= DM_PAGE_RESET;
         map_locked <= 1'b0;
      end else if (write_access && hit_map && (special_mode || !map_locked)) begin
         data_memory_page <= wd[MAP_LSB+3:MAP_LSB];
         map_locked <= !special_mode;
      end
   end

   // Window decode of the CPU address
   assign tgt.addr = mem_addr;
   assign tgt.page = data_memory_page;
   assign tgt.map_enable = data_memory_map_enable;
   assign dm_read_select = tgt.hit && !data_memory_latch_control;

   // Target selection and protection check
   assign bulk_erase_protect = block_protect[BP_BULK_ERASE_PROTECT];
   assign protect_blocks = {block_protect[BP_UPPER], block_protect[3:0]};
   assign protected_hit = |(tgt.block & protect_blocks);
   assign any_protect = |protect_blocks;
   assign scope_now = scope_of(byte_sel, row_sel);
   assign dm_capture = mem_write && tgt.hit && data_memory_latch_control;
   assign next_offset = !erase_sel ? tgt.offset :
      (scope_now == SCOPE_BYTE) ? tgt.offset :
      (scope_now == SCOPE_ROW) ? (tgt.offset & ROW_MASK) : 10'h000;
   assign next_refused = !erase_sel ? protected_hit :
      (scope_now == SCOPE_BULK) ? (bulk_erase_protect || any_protect) :
      (scope_now == SCOPE_ROW) ? (bulk_erase_protect || protected_hit) : protected_hit;

   // Latch of the data-memory target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dm_latch_offset <= 10'h000;
         dm_latch_data <= 8'h00;
         dm_erase_mode <= 1'b0;
         dm_erase_scope <= SCOPE_BULK;
         dm_op_refused <= 1'b0;
         armed <= 1'b0;
      end else if (!data_memory_latch_control) begin
         armed <= 1'b0;
      end else if (dm_capture) begin
         dm_latch_offset <= next_offset;
         dm_latch_data <= erase_sel ? ERASED_BYTE : mem_wdata;
         dm_erase_mode <= erase_sel;
         dm_erase_scope <= scope_now;
         dm_op_refused <= next_refused;
         armed <= 1'b1;
      end
   end

   // Array voltage switched by the program command
   assign next_dm_voltage = data_memory_program_command && data_memory_latch_control &&
      armed && !dm_op_refused && !low_voltage_inhibit_flag_active;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dm_voltage_on <= 1'b0;
      end else begin
         dm_voltage_on <= next_dm_voltage;
      end
   end

   // Checks on the control behaviour
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_MBE_ADDR5: assert property (pm_addr_bit5_ignore == multi_byte_program_enable)
      else $error("bit 5 ignore does not follow multi-byte enable");
   AST_PM_NORMAL_READ: assert property (
      setup_phase && !pwrite && hit_pm && !special_mode |=> prdata[PM_MBE] == 1'b0)
      else $error("multi-byte enable visible in normal mode");
   AST_PM_UNUSED: assert property (
      setup_phase && !pwrite && hit_pm |=> (prdata[6] == 1'b0) && (prdata[2:1] == 2'h0))
      else $error("unimplemented program-control bits read nonzero");
   AST_PROG_MEMORY_LATCH_CONTROL_LOCK: assert property (
      write_access && hit_pm && prog_memory_voltage_enable |=> $stable(prog_memory_latch_control))
      else $error("latch control changed while voltage enabled");
   AST_PM_NOREAD: assert property (prog_memory_latch_control |-> !pm_read_enable)
      else $error("program memory readable while latched");
   AST_EXTRA_COLUMN_SELECT_DECODE: assert property (
      extra_column_select |-> pm_decode_addr[4:0] == 5'h00 && !pm_user_array_enable)
      else $error("extra column decode wrong");
   AST_EXTRA_ROW_SELECT_DECODE: assert property (
      extra_row_select && !extra_column_select |-> pm_decode_addr[11:6] == 6'h00)
      else $error("extra row decode wrong");
   AST_EX_NORMAL: assert property (
      write_access && hit_pm && !special_mode |=> $stable(extra_column_select) &&
      $stable(extra_row_select))
      else $error("extra selects written in normal mode");
   AST_PROG_MEMORY_VOLTAGE_ENABLE_GATE: assert property (
      write_access && hit_pm && !prog_memory_latch_control |=> $stable(prog_memory_voltage_enable))
      else $error("voltage enable written without latch");
   AST_DM_UNMAPPED: assert property (data_memory_latch_control |-> !dm_read_select)
      else $error("data memory mapped during program cycle");
   AST_LOW_VOLTAGE_INHIBIT_FLAG_OFF: assert property (!low_voltage_protect_enable |-> !low_voltage_inhibit_flag_active)
      else $error("inhibit flag active with protection off");
   AST_LOW_VOLTAGE_INHIBIT_FLAG_SET: assert property (
      low_voltage_protect_enable && vdd_unsafe ##1 low_voltage_protect_enable |=> !dm_voltage_on)
      else $error("voltage applied under low supply");
   AST_ROW_SELECT: assert property (
      dm_capture && erase_sel && scope_now == SCOPE_ROW |=> dm_latch_offset[3:0] == 4'h0)
      else $error("row erase offset not row aligned");
   AST_REFUSE: assert property (dm_voltage_on |-> !$past(dm_op_refused) && $past(armed))
      else $error("voltage applied to protected target");
   AST_BULK_ERASE_PROTECT: assert property (
      dm_capture && erase_sel && !byte_sel && bulk_erase_protect |=> dm_op_refused)
      else $error("bulk or row erase not refused");
   AST_BLOCK_PROTECT_ONCE: assert property (
      write_access && hit_bp && !special_mode && !window_open |=>
      ($past(block_protect) & ~block_protect) == 8'h00)
      else $error("protect bit cleared outside window");

   COV_PM_PROGRAM: cover property (pm_write && prog_memory_latch_control ##[1:50] pm_voltage_on);
   COV_DM_PROGRAM: cover property (dm_capture && !erase_sel ##[1:50] dm_voltage_on);
   COV_ROW_ERASE: cover property (dm_capture && erase_sel && scope_now == SCOPE_ROW);
   COV_REFUSED: cover property (dm_capture && next_refused);
endmodule
`default_nettype wire

// *** src/nvm_pkg.sv ***
/*
 Constants, types and helpers shared by the nonvolatile-memory program control.
 Assumes a 100 MHz pclk and an APB register window decoded on 12 address bits.
*/
package nvm_pkg;
   // Register byte addresses on APB
   localparam logic [11:0] OFS_PM_CTRL = 12'h000;
   localparam logic [11:0] OFS_DM_CTRL = 12'h004;
   localparam logic [11:0] OFS_BLOCK_PROTECT = 12'h008;
   localparam logic [11:0] OFS_DM_MAP = 12'h00c;
   // Program-memory control fields
   localparam int PM_MBE = 7;
   localparam int PM_PROG_MEMORY_LATCH_CONTROL = 5;
   localparam int PM_EXTRA_COLUMN_SELECT = 4;
   localparam int PM_EXTRA_ROW_SELECT = 3;
   localparam int PM_PROG_MEMORY_VOLTAGE_ENABLE = 0;
   // Data-memory control fields
   localparam int DM_LOW_VOLTAGE_INHIBIT_FLAG = 5;
   localparam int DM_BYTE = 4;
   localparam int DM_ROW = 3;
   localparam int DM_ERASE = 2;
   localparam int DM_DATA_MEMORY_LATCH_CONTROL = 1;
   localparam int DM_DATA_MEMORY_PROGRAM_COMMAND = 0;
   // Block-protect fields
   localparam int BP_BULK_ERASE_PROTECT = 7;
   localparam int BP_LOW_VOLTAGE_PROTECT_ENABLE = 6;
   localparam int BP_UPPER = 5;
   localparam int BP_CFG = 4;
   // Map register field
   localparam int MAP_LSB = 4;
   // Reset values
   localparam logic [7:0] PM_CTRL_RESET = 8'h00;
   localparam logic [7:0] DM_CTRL_RESET = 8'h00;
   localparam logic [7:0] BLOCK_PROTECT_RESET = 8'hff;
   localparam logic [3:0] DM_PAGE_RESET = 4'h0;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // Data-memory placement inside a 4-Kbyte page
   localparam logic [11:0] DM_BASE = 12'hd80;
   localparam int DM_BYTES = 640;
   localparam logic [9:0] ROW_MASK = 10'h3f0;
   // Block boundaries as offsets from the base
   localparam logic [9:0] BLK1_START = 10'h020;
   localparam logic [9:0] BLK2_START = 10'h060;
   localparam logic [9:0] BLK3_START = 10'h0e0;
   localparam logic [9:0] BLK4_START = 10'h200;
   // Protect-clear window after reset
   localparam logic [6:0] BLOCK_PROTECT_WINDOW = 7'h40;
   // Software hold times for the voltage enables
   localparam int CLK_MHZ = 100;
   localparam int PM_HOLD_US = 2000;
   localparam int DM_HOLD_US = 10000;
   localparam int PM_HOLD_CYCLES = PM_HOLD_US * CLK_MHZ;
   localparam int DM_HOLD_CYCLES = DM_HOLD_US * CLK_MHZ;

   typedef enum logic [1:0] {SCOPE_BULK, SCOPE_ROW, SCOPE_BYTE} erase_scope_type;

   // Byte select wins over row select
   function automatic erase_scope_type scope_of(input logic byte_sel, input logic row_sel);
      if (byte_sel) begin
         return SCOPE_BYTE;
      end
      return row_sel ? SCOPE_ROW : SCOPE_BULK;
   endfunction

   // One-hot protect block of a data-memory offset
   function automatic logic [4:0] block_of(input logic [9:0] ofs);
      if (ofs >= BLK4_START) begin
         return 5'h10;
      end
      if (ofs >= BLK3_START) begin
         return 5'h08;
      end
      if (ofs >= BLK2_START) begin
         return 5'h04;
      end
      return (ofs >= BLK1_START) ? 5'h02 : 5'h01;
   endfunction
endpackage

// *** src/dm_target_if.sv ***
/*
 Carries a CPU address to the data-memory decoder and its verdict back.
 Assumes both ends sit in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface dm_target_if;
   logic [15:0] addr;
   logic [3:0] page;
   logic map_enable;
   logic hit;
   logic [9:0] offset;
   logic [4:0] block;
   modport decoder(input addr, page, map_enable, output hit, offset, block);
   modport user(output addr, page, map_enable, input hit, offset, block);
endinterface
`default_nettype wire

// *** src/dm_target_decode.sv ***
/*
 Decodes a CPU address against the movable data-memory window.
 Assumes the window page and enable come from the control block.
*/
`timescale 1ns/1ps
`default_nettype none
module dm_target_decode
   import nvm_pkg::*;
(
   dm_target_if.decoder t
);
   logic [11:0] diff;

   // Window at page:D80..FFF when enabled
   assign diff = t.addr[11:0] - DM_BASE;
   assign t.hit = t.map_enable && (t.addr[15:12] == t.page) && (t.addr[11:0] >= DM_BASE);
   assign t.offset = diff[9:0];
   assign t.block = block_of(diff[9:0]);
endmodule
`default_nettype wire

// *** bench/test_eprom_eeprom_program_control.sv ***
/*
 Self-checking bench for the program control block, driven over APB.
 Assumes zero-wait APB answers, a 100 MHz pclk and the package offsets.
*/
`timescale 1ns/1ps
`default_nettype none
module test_eprom_eeprom_program_control
   import nvm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, special_mode, data_memory_map_enable;
   logic vdd_unsafe, mem_write, pm_write, pready, pslverr, pm_read_enable;
   logic pm_user_array_enable, pm_addr_bit5_ignore, pm_voltage_on, dm_read_select;
   logic dm_erase_mode, dm_op_refused, dm_voltage_on;
   logic [11:0] paddr, pm_decode_addr;
   logic [31:0] pwdata, prdata;
   logic [15:0] mem_addr, pm_latch_addr, a;
   logic [7:0] mem_wdata, pm_latch_data, dm_latch_data, d;
   logic [9:0] dm_latch_offset, off;
   erase_scope_type dm_erase_scope;
   logic [32:0] q[$];
   int n_mismatch = 0;
   int checks = 0;

   eprom_eeprom_program_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .special_mode, .data_memory_map_enable,
      .vdd_unsafe, .mem_addr, .mem_write, .mem_wdata, .pm_write, .pm_read_enable,
      .pm_user_array_enable, .pm_decode_addr, .pm_addr_bit5_ignore, .pm_latch_addr,
      .pm_latch_data, .pm_voltage_on, .dm_read_select, .dm_latch_offset, .dm_latch_data,
      .dm_erase_mode, .dm_erase_scope, .dm_op_refused, .dm_voltage_on);

   // Free-running 100 MHz clock, far above 1 MHz
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   // Read answers compared with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         checks++;
         if (q.size() == 0 || {pslverr, prdata} !== q[0]) begin
            n_mismatch++;
            $display("BAD %0t read gave %h", $time, {pslverr, prdata});
         end
         if (q.size() != 0) void'(q.pop_front());
      end
   end

   task automatic test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] dt,
                      input logic [32:0] e = '0);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {24'h0, dt};
      if (!w) q.push_back(e);
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("BAD %0t no answer", $time);
         test_done();
      end
      psel <= 0;
      penable <= 0;
      #1;
   endtask

   task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
      apb(1, ad, dt);
   endtask

   task automatic rd(input logic [11:0] ad, input logic [7:0] e);
      apb(0, ad, 8'h00, {25'h0, e});
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask

   task automatic tick;
      @(posedge pclk);
      #1;
   endtask

   task automatic setm(input logic v);
      @(posedge pclk);
      special_mode <= v;
   endtask

   // One CPU write cycle to program or data memory
   task automatic mw(input logic pm, input logic [15:0] ad, input logic [7:0] dt);
      @(posedge pclk);
      mem_addr <= ad;
      mem_wdata <= dt;
      mem_write <= !pm;
      pm_write <= pm;
      @(posedge pclk);
      mem_write <= 0;
      pm_write <= 0;
      #1;
   endtask

   task automatic sel(input logic [15:0] ad, input logic e);
      @(posedge pclk);
      mem_addr <= ad;
      #1;
      chk(dm_read_select, e);
   endtask

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, special_mode, vdd_unsafe, mem_write, pm_write} = '0;
      data_memory_map_enable = 1;
      {paddr, pwdata, mem_addr, mem_wdata} = '0;
      void'($urandom(84));
      repeat (12) @(posedge pclk);
      presetn <= 1;
      rd(OFS_PM_CTRL, 8'h00);
      rd(OFS_DM_CTRL, 8'h00);
      rd(OFS_BLOCK_PROTECT, 8'hff);
      rd(OFS_DM_MAP, 8'h00);
      apb(0, 12'h010, 8'h00, {1'b1, 32'h0});
      wr(OFS_BLOCK_PROTECT, 8'h40);
      wr(OFS_BLOCK_PROTECT, 8'h00);
      rd(OFS_BLOCK_PROTECT, 8'h40);
      $display("reset and protect window test done");
      wr(OFS_PM_CTRL, 8'h01);
      rd(OFS_PM_CTRL, 8'h00);
      wr(OFS_PM_CTRL, 8'h20);
      rd(OFS_PM_CTRL, 8'h20);
      chk(pm_read_enable, 1'b0);
      a = $urandom;
      d = $urandom;
      mw(1, a, d);
      chk(pm_latch_addr, a);
      chk(pm_latch_data, d);
      wr(OFS_PM_CTRL, 8'hff);
      rd(OFS_PM_CTRL, 8'h21);
      chk(pm_voltage_on, 1'b1);
      // Voltage off before the control clear; no hold time waited, for run length
      wr(OFS_PM_CTRL, 8'h00);
      rd(OFS_PM_CTRL, 8'h20);
      chk(pm_voltage_on, 1'b0);
      wr(OFS_PM_CTRL, 8'h00);
      setm(1);
      wr(OFS_PM_CTRL, 8'h90);
      rd(OFS_PM_CTRL, 8'h90);
      sel(a | 16'h1000, 1'b0);
      chk(pm_addr_bit5_ignore, 1'b1);
      chk(pm_user_array_enable, 1'b0);
      chk(pm_decode_addr, {a[11:5], 5'h00});
      wr(OFS_PM_CTRL, 8'h88);
      chk(pm_decode_addr, {6'h00, a[5:0]});
      setm(0);
      wr(OFS_PM_CTRL, 8'h00);
      rd(OFS_PM_CTRL, 8'h00);
      setm(1);
      rd(OFS_PM_CTRL, 8'h88);
      wr(OFS_PM_CTRL, 8'h00);
      setm(0);
      $display("program memory test done");
      off = 10'($urandom % 640);
      a = 16'h0d80 + 16'(off);
      sel(a, 1'b1);
      wr(OFS_DM_CTRL, 8'h02);
      chk(dm_read_select, 1'b0);
      mw(0, a, d);
      chk(dm_latch_offset, off);
      chk(dm_latch_data, d);
      chk(dm_erase_mode, 1'b0);
      wr(OFS_DM_CTRL, 8'h03);
      tick();
      chk(dm_voltage_on, 1'b1);
      wr(OFS_DM_CTRL, 8'h02);
      tick();
      chk(dm_voltage_on, 1'b0);
      wr(OFS_DM_CTRL, 8'h00);
      // Every erase scope, without and with bulk protection
      for (int p = 0; p < 2; p++) begin
         if (p == 1) wr(OFS_BLOCK_PROTECT, 8'hc1);
         for (int s = 0; s < 4; s++) begin
            off = 10'h200 + 10'($urandom % 128);
            wr(OFS_DM_CTRL, 8'h06 | 8'(s << 3));
            mw(0, 16'h0d80 + 16'(off), d);
            chk(dm_erase_mode, 1'b1);
            chk(dm_latch_data, 8'hff);
            chk(dm_latch_offset, s == 0 ? 10'h000 : s == 1 ? off & ROW_MASK : off);
            chk(dm_erase_scope, {s[1], s[0] & !s[1]});
            chk(dm_op_refused, p == 1 && !s[1]);
            wr(OFS_DM_CTRL, 8'h00);
         end
      end
      rd(OFS_BLOCK_PROTECT, 8'hc1);
      wr(OFS_DM_CTRL, 8'h02);
      mw(0, 16'h0d85, d);
      chk(dm_op_refused, 1'b1);
      wr(OFS_DM_CTRL, 8'h03);
      tick();
      chk(dm_voltage_on, 1'b0);
      wr(OFS_DM_CTRL, 8'h00);
      $display("data memory test done");
      @(posedge pclk) vdd_unsafe <= 1;
      tick();
      rd(OFS_DM_CTRL, 8'h20);
      wr(OFS_DM_CTRL, 8'h02);
      mw(0, 16'h0f00, d);
      wr(OFS_DM_CTRL, 8'h03);
      tick();
      chk(dm_voltage_on, 1'b0);
      wr(OFS_DM_CTRL, 8'h00);
      setm(1);
      wr(OFS_BLOCK_PROTECT, 8'h81);
      setm(0);
      tick();
      rd(OFS_DM_CTRL, 8'h00);
      wr(OFS_DM_CTRL, 8'h02);
      mw(0, 16'h0f00, d);
      wr(OFS_DM_CTRL, 8'h03);
      tick();
      chk(dm_voltage_on, 1'b1);
      wr(OFS_DM_CTRL, 8'h00);
      @(posedge pclk) vdd_unsafe <= 0;
      $display("low voltage test done");
      wr(OFS_DM_MAP, 8'h30);
      rd(OFS_DM_MAP, 8'h30);
      sel(16'h3d80, 1'b1);
      sel(16'h0d80, 1'b0);
      @(posedge pclk) data_memory_map_enable <= 0;
      sel(16'h3d80, 1'b0);
      @(posedge pclk) presetn <= 0;
      @(posedge pclk) presetn <= 1;
      rd(OFS_BLOCK_PROTECT, 8'hff);
      rd(OFS_DM_MAP, 8'h00);
      $display("map and second reset test done");
      test_done();
   end
endmodule
`default_nettype wire
